// *** logic/pmis_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmis_top #(
  parameter longint NVM_CYC    = pmis_pkg::NVM_LOAD_CYC,
  parameter longint SAMPLE_CYC = pmis_pkg::SAMPLE_CYC
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        inputSelPin,
  input  wire logic        inputZeroValid,
  input  wire logic        inputOneValid,
  input  wire logic        pllLockDet,
  input  wire logic [23:0] measFreq,
  output logic             outputsEnable,
  output logic             lockLostIndicator,
  output logic             fastBwActive,
  output logic [4:0]       activeBw,
  output logic             selInputOne,
  output logic             outerLoopEnable,
  output logic             holdoverActive,
  output logic [23:0]      holdoverFreq,
  output logic             extRefSelect,
  output logic             loadCapEnable,
  output logic [7:0]       refPreDiv,
  output logic [15:0]      xtalAdjust,
  output logic [31:0]      innerFbNumerator,
  output logic [2:0]       modeCode
);
  pmis_pkg::pmis_mode_e mode_q;
  pmis_pkg::pmis_mode_e mode_d;
  // Live configuration
  logic        fastEn_q, selReg_q, selVal_q, dcoEn_q;
  logic [4:0]  bwNorm_q, bwFast_q;
  logic [6:0]  win_q, dly_q;
  logic        ext_q;
  logic [7:0]  preDiv_q;
  logic [15:0] adj_q;
  logic [31:0] dcoNum_q;
  // Shadow configuration applied by soft reset
  logic        fastEnS_q, selRegS_q, selValS_q, dcoEnS_q;
  logic [4:0]  bwNormS_q, bwFastS_q;
  logic [6:0]  winS_q, dlyS_q;
  logic        extS_q;
  logic [7:0]  preDivS_q;
  logic [15:0] adjS_q;
  logic [31:0] initCnt_q;
  logic [31:0] smpCnt_q;
  logic        hardReq_q;
  logic        softReq_q;
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        lol_q;
  logic        outEn_q;
  logic        fastAct_q;
  logic [4:0]  bw_q;
  logic        sel_q;
  logic [23:0] hfreq_q;
  logic        calcStart;
  logic        calcBusy;
  logic [23:0] avgOut;
  // Hard reset covers pin and register bit
  wire inReset = !rst_n || hardReq_q;
  wire initDone = (mode_q != pmis_pkg::MODE_INIT);
  // Bus decode
  wire setup   = psel && !penable;
  wire access  = psel && penable && pready_q;
  wire wrEn    = access && pwrite && initDone;
  wire hitCtrl = (paddr == pmis_pkg::ADDR_CTRL);
  wire hitBw   = (paddr == pmis_pkg::ADDR_BW);
  wire hitHold = (paddr == pmis_pkg::ADDR_HOLD);
  wire hitRef  = (paddr == pmis_pkg::ADDR_REF);
  wire hitDco  = (paddr == pmis_pkg::ADDR_DCO);
  wire hitSt   = (paddr == pmis_pkg::ADDR_STATUS);
  wire hitHf   = (paddr == pmis_pkg::ADDR_HOLDFRQ);
  wire hitFi   = (paddr == pmis_pkg::ADDR_FREQIN);
  wire mapped  = hitCtrl || hitBw || hitHold || hitRef || hitDco || hitSt || hitHf || hitFi;
  // Clamped written fields
  wire [4:0] wBwN = (pwdata[4:0] > pmis_pkg::BW_MAX) ? pmis_pkg::BW_MAX : pwdata[4:0];
  wire [4:0] wBwF = (pwdata[12:8] > pmis_pkg::BW_MAX) ? pmis_pkg::BW_MAX :
                    (pwdata[12:8] < pmis_pkg::FAST_MIN) ? pmis_pkg::FAST_MIN :
                    pwdata[12:8];
  wire signed [15:0] wAdjRaw = pwdata[pmis_pkg::REF_ADJ_LO +: 16];
  wire [15:0] wAdj = (wAdjRaw > pmis_pkg::ADJ_LIMIT_PPM) ? pmis_pkg::ADJ_LIMIT_PPM :
                     (wAdjRaw < -pmis_pkg::ADJ_LIMIT_PPM) ? 16'(-pmis_pkg::ADJ_LIMIT_PPM) :
                     wAdjRaw;
  // Manual input choice
  wire selNext = selReg_q ? selVal_q : inputSelPin;
  wire selValid = selNext ? inputOneValid : inputZeroValid;
  wire anyValid = inputZeroValid || inputOneValid;
  wire acqBw = fastEn_q && (mode_q == pmis_pkg::MODE_ACQUIRE);
  wire [4:0] bwNext = acqBw ? bwFast_q : bwNorm_q;
  wire smpTick = (smpCnt_q == 32'(SAMPLE_CYC - 1));
  wire logHist = smpTick && (mode_q == pmis_pkg::MODE_LOCKED);
  // Status word
  wire [31:0] stWord = {24'h000000, calcBusy, fastAct_q, sel_q, outEn_q, lol_q, mode_q};
  wire [31:0] rdMux =
    hitCtrl ? {26'h0000000, dcoEn_q, selVal_q, selReg_q, fastEn_q, 2'h0} :
    hitBw   ? {19'h00000, bwFast_q, 3'h0, bwNorm_q} :
    hitHold ? {17'h00000, dly_q, 1'h0, win_q} :
    hitRef  ? {adj_q, preDiv_q, 7'h00, ext_q} :
    hitDco  ? dcoNum_q :
    hitSt   ? stWord :
    hitHf   ? {8'h00, hfreq_q} :
    hitFi   ? {8'h00, measFreq} : 32'h00000000;
  // Mode machine; a selected input without clock falls back
  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      pmis_pkg::MODE_INIT:
        if (initCnt_q == 32'(NVM_CYC - 1))
          mode_d = pmis_pkg::MODE_FREERUN;
      pmis_pkg::MODE_FREERUN:
        if (!dcoEn_q && selValid)
          mode_d = pmis_pkg::MODE_ACQUIRE;
      pmis_pkg::MODE_ACQUIRE:
        if (dcoEn_q)
          mode_d = pmis_pkg::MODE_FREERUN;
        else if (!selValid)
          mode_d = pmis_pkg::MODE_FREERUN;
        else if (pllLockDet)
          mode_d = pmis_pkg::MODE_LOCKED;
      pmis_pkg::MODE_LOCKED:
        if (dcoEn_q)
          mode_d = pmis_pkg::MODE_FREERUN;
        else if (!selValid)
          mode_d = pmis_pkg::MODE_HOLDOVER;
        else if (!pllLockDet)
          mode_d = pmis_pkg::MODE_ACQUIRE;
      pmis_pkg::MODE_HOLDOVER:
        if (dcoEn_q)
          mode_d = pmis_pkg::MODE_FREERUN;
        else if (selValid)
          mode_d = pmis_pkg::MODE_ACQUIRE;
      default:
        mode_d = pmis_pkg::MODE_INIT;
    endcase
  end
  assign calcStart = (mode_q == pmis_pkg::MODE_LOCKED) && (mode_d == pmis_pkg::MODE_HOLDOVER);
  // Mode, init counter and sample counter
  always_ff @(posedge mclk)
  begin
    if (inReset)
    begin
      mode_q <= pmis_pkg::MODE_INIT;
      initCnt_q <= 32'h00000000;
      smpCnt_q <= 32'h00000000;
    end
    else
    begin
      mode_q <= mode_d;
      if (!initDone)
        initCnt_q <= initCnt_q + 32'h00000001;
      smpCnt_q <= smpTick ? 32'h00000000 : smpCnt_q + 32'h00000001;
    end
  end
  // Live configuration: defaults on hard reset, shadow on soft reset
  always_ff @(posedge mclk)
  begin
    if (inReset)
    begin
      fastEn_q <= 1'b1;
      selReg_q <= 1'b0;
      selVal_q <= 1'b0;
      dcoEn_q <= 1'b0;
      bwNorm_q <= pmis_pkg::BW_RST;
      bwFast_q <= pmis_pkg::FAST_RST;
      win_q <= pmis_pkg::WIN_RST;
      dly_q <= pmis_pkg::DLY_RST;
      ext_q <= 1'b0;
      preDiv_q <= 8'h01;
      adj_q <= 16'h0000;
    end
    else if (softReq_q)
    begin
      fastEn_q <= fastEnS_q;
      selReg_q <= selRegS_q;
      selVal_q <= selValS_q;
      dcoEn_q <= dcoEnS_q;
      bwNorm_q <= bwNormS_q;
      bwFast_q <= bwFastS_q;
      win_q <= winS_q;
      dly_q <= dlyS_q;
      ext_q <= extS_q;
      preDiv_q <= preDivS_q;
      adj_q <= adjS_q;
    end
  end
  // Shadow registers and live DCO numerator written by software
  always_ff @(posedge mclk)
  begin
    if (inReset)
    begin
      fastEnS_q <= 1'b1;
      selRegS_q <= 1'b0;
      selValS_q <= 1'b0;
      dcoEnS_q <= 1'b0;
      bwNormS_q <= pmis_pkg::BW_RST;
      bwFastS_q <= pmis_pkg::FAST_RST;
      winS_q <= pmis_pkg::WIN_RST;
      dlyS_q <= pmis_pkg::DLY_RST;
      extS_q <= 1'b0;
      preDivS_q <= 8'h01;
      adjS_q <= 16'h0000;
      dcoNum_q <= 32'h00000000;
    end
    else if (wrEn)
    begin
      if (hitCtrl)
      begin
        fastEnS_q <= pwdata[pmis_pkg::CTRL_FASTEN];
        selRegS_q <= pwdata[pmis_pkg::CTRL_SELREG];
        selValS_q <= pwdata[pmis_pkg::CTRL_SELVAL];
        dcoEnS_q <= pwdata[pmis_pkg::CTRL_DCOEN];
      end
      if (hitBw)
      begin
        bwNormS_q <= wBwN;
        bwFastS_q <= wBwF;
      end
      if (hitHold)
      begin
        winS_q <= pwdata[6:0];
        dlyS_q <= pwdata[14:8];
      end
      if (hitRef)
      begin
        extS_q <= pwdata[pmis_pkg::REF_EXTCLK];
        preDivS_q <= pwdata[pmis_pkg::REF_PREDIV_LO +: 8];
        adjS_q <= wAdj;
      end
      if (hitDco)
        dcoNum_q <= pwdata;
    end
  end
  // Reset requests from the control register
  always_ff @(posedge mclk)
  begin
    if (!rst_n || hardReq_q)
    begin
      hardReq_q <= 1'b0;
      softReq_q <= 1'b0;
    end
    else
    begin
      hardReq_q <= wrEn && hitCtrl && pwdata[pmis_pkg::CTRL_HARD];
      softReq_q <= wrEn && hitCtrl && pwdata[pmis_pkg::CTRL_SOFT];
    end
  end
  // APB slave: no wait states, refuses all access during init
  always_ff @(posedge mclk)
  begin
    if (inReset)
    begin
      pready_q <= 1'b0;
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q <= (initDone && !pwrite) ? rdMux : 32'h00000000;
        pslverr_q <= !initDone || !mapped;
      end
    end
  end
  // Registered outputs
  always_ff @(posedge mclk)
  begin
    if (inReset)
    begin
      lol_q <= 1'b1;
      outEn_q <= 1'b0;
      fastAct_q <= 1'b0;
      bw_q <= pmis_pkg::BW_RST;
      sel_q <= 1'b0;
      hfreq_q <= 24'h000000;
    end
    else
    begin
      lol_q <= (mode_d != pmis_pkg::MODE_LOCKED);
      outEn_q <= (mode_d != pmis_pkg::MODE_INIT);
      fastAct_q <= acqBw;
      bw_q <= bwNext;
      sel_q <= selNext;
      if (!calcBusy && mode_q == pmis_pkg::MODE_HOLDOVER)
        hfreq_q <= avgOut;
    end
  end
  pmis_hold_avg u_hold (
    .mclk      (mclk),
    .clr       (inReset),
    .sampleEn  (logHist),
    .freqIn    (measFreq),
    .winLen    (win_q),
    .delayLen  (dly_q),
    .calcStart (calcStart),
    .calcBusy  (calcBusy),
    .avgOut    (avgOut)
  );
  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign outputsEnable = outEn_q;
  assign lockLostIndicator = lol_q;
  assign fastBwActive = fastAct_q;
  assign activeBw = bw_q;
  assign selInputOne = sel_q;
  assign outerLoopEnable = !dcoEn_q;
  assign holdoverActive = (mode_q == pmis_pkg::MODE_HOLDOVER);
  assign holdoverFreq = hfreq_q;
  assign extRefSelect = ext_q;
  assign loadCapEnable = !ext_q;
  assign refPreDiv = preDiv_q;
  assign xtalAdjust = adj_q;
  assign innerFbNumerator = dcoNum_q;
  assign modeCode = mode_q;
endmodule
`default_nettype wire

// *** include/pmis_pkg.sv ***
`default_nettype none
package pmis_pkg;
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_BW      = 12'h004;
  localparam logic [11:0] ADDR_HOLD    = 12'h008;
  localparam logic [11:0] ADDR_REF     = 12'h00C;
  localparam logic [11:0] ADDR_DCO     = 12'h010;
  localparam logic [11:0] ADDR_STATUS  = 12'h014;
  localparam logic [11:0] ADDR_HOLDFRQ = 12'h018;
  localparam logic [11:0] ADDR_FREQIN  = 12'h01C;
  // CTRL fields
  localparam int CTRL_HARD    = 0;
  localparam int CTRL_SOFT    = 1;
  localparam int CTRL_FASTEN  = 2;
  localparam int CTRL_SELREG  = 3;
  localparam int CTRL_SELVAL  = 4;
  localparam int CTRL_DCOEN   = 5;
  // REF fields
  localparam int REF_EXTCLK   = 0;
  localparam int REF_PREDIV_LO = 8;
  localparam int REF_ADJ_LO   = 16;
  // Bandwidth code limits: 0 = 0.1 Hz step up to top = 4 kHz
  localparam logic [4:0] BW_MAX      = 5'h10;
  localparam logic [4:0] FAST_MIN    = 5'h0A; // 100 Hz
  localparam logic [4:0] BW_RST      = 5'h08;
  localparam logic [4:0] FAST_RST    = 5'h0C;
  // Crystal adjust limit, ppm
  localparam logic signed [15:0] ADJ_LIMIT_PPM = 16'sh00C8;
  // Holdover history
  localparam int HIST_DEPTH = 128;
  localparam int HIST_AW    = 7;
  localparam int HIST_SECONDS = 120;
  localparam logic [6:0] WIN_RST = 7'h10;
  localparam logic [6:0] DLY_RST = 7'h02;
  // Sample period of history, one sample per second
  localparam longint CLK_HZ = 250000000;
  localparam longint SAMPLE_NS = 1000000000;
  localparam longint SAMPLE_CYC = SAMPLE_NS * CLK_HZ / 1000000000;
  // Non-volatile load time
  localparam longint NVM_LOAD_US = 100;
  localparam longint NVM_LOAD_CYC = NVM_LOAD_US * CLK_HZ / 1000000;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_INIT,
    MODE_FREERUN,
    MODE_ACQUIRE,
    MODE_LOCKED,
    MODE_HOLDOVER
  } pmis_mode_e;
  localparam logic [2:0] ST_INIT = 3'h0;
  localparam logic [2:0] ST_FREE = 3'h1;
  localparam logic [2:0] ST_ACQ  = 3'h2;
  localparam logic [2:0] ST_LOCK = 3'h3;
  localparam logic [2:0] ST_HOLD = 3'h4;
endpackage
`default_nettype wire

// *** logic/pmis_hold_avg.sv ***
`timescale 1ns/1ps
`default_nettype none
// Holdover history store and windowed average
module pmis_hold_avg (
  input  wire logic        mclk,
  input  wire logic        clr,
  input  wire logic        sampleEn,
  input  wire logic [23:0] freqIn,
  input  wire logic [6:0]  winLen,
  input  wire logic [6:0]  delayLen,
  input  wire logic        calcStart,
  output logic             calcBusy,
  output logic [23:0]      avgOut
);
  logic [23:0] histMem [pmis_pkg::HIST_DEPTH];
  logic [6:0]  wrPtr_q;
  logic [6:0]  fill_q;
  logic [6:0]  rdPtr_q;
  logic [6:0]  cnt_q;
  logic [6:0]  cntTot_q;
  logic [30:0] acc_q;
  logic        busy_q;
  logic [23:0] avg_q;
  wire  [6:0]  winUse  = (winLen == 7'h00) ? 7'h01 : winLen;
  wire  [6:0]  startPt = wrPtr_q - 7'h01 - delayLen;
  wire  [30:0] accNext = acc_q + {7'h00, histMem[rdPtr_q]};
  wire         lastSmp = (cnt_q == cntTot_q - 7'h01);
  // History ring, one word per sample period
  always_ff @(posedge mclk)
  begin
    if (sampleEn && !busy_q)
    begin
      histMem[wrPtr_q] <= freqIn;
    end
  end
  // Pointers, accumulation and division
  always_ff @(posedge mclk)
  begin
    if (clr)
    begin
      wrPtr_q <= 7'h00;
      fill_q <= 7'h00;
      busy_q <= 1'b0;
      acc_q <= 31'h00000000;
      cnt_q <= 7'h00;
      cntTot_q <= 7'h01;
      rdPtr_q <= 7'h00;
      avg_q <= 24'h000000;
    end
    else if (calcStart && !busy_q)
    begin
      busy_q <= 1'b1;
      rdPtr_q <= startPt - winUse + 7'h01;
      cntTot_q <= winUse;
      cnt_q <= 7'h00;
      acc_q <= 31'h00000000;
    end
    else if (busy_q)
    begin
      acc_q <= accNext;
      rdPtr_q <= rdPtr_q + 7'h01;
      cnt_q <= cnt_q + 7'h01;
      if (lastSmp)
      begin
        busy_q <= 1'b0;
        avg_q <= 24'(accNext / {24'h000000, cntTot_q});
      end
    end
    else if (sampleEn)
    begin
      wrPtr_q <= wrPtr_q + 7'h01;
      if (fill_q != 7'h7F)
        fill_q <= fill_q + 7'h01;
    end
  end
  assign calcBusy = busy_q;
  assign avgOut = avg_q;
endmodule
`default_nettype wire

// *** tb/pmis_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of mode, lock and reference outputs
module pmis_monitor (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [2:0] modeCode,
  input wire logic       outputsEnable,
  input wire logic       lockLostIndicator,
  input wire logic       fastBwActive,
  input wire logic       holdoverActive,
  input wire logic       extRefSelect,
  input wire logic       loadCapEnable,
  input wire logic       outerLoopEnable,
  input wire logic       pready,
  input wire logic       pslverr
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  chk_init_dark: assert property (
    modeCode == pmis_pkg::ST_INIT |-> !outputsEnable) else $error("outputs on in init");
  chk_mode_range: assert property (
    modeCode <= pmis_pkg::ST_HOLD) else $error("illegal mode code");
  chk_hold_flag: assert property (
    holdoverActive == (modeCode == pmis_pkg::ST_HOLD)) else $error("holdover flag wrong");
  chk_lock_pin: assert property (
    (modeCode == pmis_pkg::ST_LOCK) [*2] |-> !lockLostIndicator) else $error("lol while locked");
  chk_load_cap: assert property (
    extRefSelect |-> !loadCapEnable) else $error("load caps on with ext ref");
  chk_fast_acq: assert property (
    fastBwActive |-> modeCode == pmis_pkg::ST_ACQ || $past(modeCode) == pmis_pkg::ST_ACQ)
    else $error("fast bandwidth outside acquisition");
  chk_dco_free: assert property (
    (!outerLoopEnable && modeCode != pmis_pkg::ST_INIT) [*3] |-> modeCode == pmis_pkg::ST_FREE)
    else $error("oscillator mode not free-run");
  chk_init_refuse: assert property (
    pready && modeCode == pmis_pkg::ST_INIT && $past(modeCode) == pmis_pkg::ST_INIT |-> pslverr)
    else $error("access accepted in init");
endmodule
bind pmis_top pmis_monitor pmis_monitor_i (.mclk, .rst_n, .modeCode, .outputsEnable,
  .lockLostIndicator, .fastBwActive, .holdoverActive, .extRefSelect, .loadCapEnable,
  .outerLoopEnable, .pready, .pslverr);
`default_nettype wire

// *** tb/pmis_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// Input clocks and analog loop lock detector
module pmis_partner (
  input  wire logic        mclk,
  input  wire logic        clkZeroOn,
  input  wire logic        clkOneOn,
  input  wire logic        selInputOne,
  input  wire logic        outerLoopEnable,
  input  wire logic [7:0]  lockDelay,
  input  wire logic [23:0] freqWord,
  output logic             inputZeroValid,
  output logic             inputOneValid,
  output logic             pllLockDet,
  output logic [23:0]      measFreq
);
  logic [7:0] lockCnt;
  logic       selOk;
  // Qualified inputs follow clock presence
  assign inputZeroValid = clkZeroOn;
  assign inputOneValid  = clkOneOn;
  assign selOk          = selInputOne ? clkOneOn : clkZeroOn;
  // Loop settles lockDelay cycles after a usable input appears
  always_ff @(posedge mclk)
    lockCnt <= (selOk && outerLoopEnable) ? lockCnt + {7'h00, lockCnt != 8'hFF} : 8'h00;
  assign pllLockDet = selOk && outerLoopEnable && lockCnt >= lockDelay;
  // Measurement is garbage without a selected clock
  assign measFreq = selOk ? freqWord : ~freqWord;
endmodule
`default_nettype wire

// *** tb/pmis_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module pmis_bench;
  localparam logic [23:0] FW = 24'h3C1234;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, err, inputSelPin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, innerFbNumerator;
  logic        inputZeroValid, inputOneValid, pllLockDet, outputsEnable, lockLostIndicator;
  logic        fastBwActive, selInputOne, outerLoopEnable, holdoverActive;
  logic        extRefSelect, loadCapEnable, clkZeroOn, clkOneOn;
  logic [23:0] measFreq, holdoverFreq;
  logic [4:0]  activeBw;
  logic [7:0]  refPreDiv, lockDelay;
  logic [15:0] xtalAdjust;
  logic [2:0]  modeCode;
  int          errors, total_checks, cycles;
  pmis_top #(.NVM_CYC(10), .SAMPLE_CYC(4)) pmis_top_i (.mclk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .inputSelPin, .inputZeroValid,
    .inputOneValid, .pllLockDet, .measFreq, .outputsEnable, .lockLostIndicator,
    .fastBwActive, .activeBw, .selInputOne, .outerLoopEnable, .holdoverActive,
    .holdoverFreq, .extRefSelect, .loadCapEnable, .refPreDiv, .xtalAdjust,
    .innerFbNumerator, .modeCode);
  pmis_partner pmis_partner_i (.mclk, .clkZeroOn, .clkOneOn, .selInputOne,
    .outerLoopEnable, .lockDelay, .freqWord(FW), .inputZeroValid, .inputOneValid,
    .pllLockDet, .measFreq);
  // Clock and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      errors++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask
  task automatic waitMode(input logic [2:0] m);
    int n;
    n = 0;
    while (modeCode !== m && n < 500)
    begin
      @(negedge mclk);
      n++;
    end
    chk("mode", {29'h0, m}, {29'h0, modeCode});
  endtask
  task automatic waitN(input int n);
    repeat (n) @(negedge mclk);
  endtask
  initial
  begin
    {errors, total_checks, cycles} = '0;
    {rst_n, psel, penable, pwrite, inputSelPin, clkZeroOn, clkOneOn} = '0;
    {paddr, pwdata, err} = '0;
    lockDelay = 8'h14;
    repeat (2) @(posedge mclk);
    waitN(1);
    chk("outEnRst", 0, outputsEnable);
    chk("lolRst", 1, lockLostIndicator);
    chk("bwRst", 32'h08, activeBw);
    chk("prediv", 1, refPreDiv);
    @(posedge mclk) rst_n <= 1'b1;
    apb(1'b0, pmis_pkg::ADDR_STATUS, 32'h0);
    chk("initErr", 1, err);
    chk("outEnInit", 0, outputsEnable);
    waitMode(pmis_pkg::ST_FREE);
    chk("outEn", 1, outputsEnable);
    rdchk("ctrl", pmis_pkg::ADDR_CTRL, 32'h4);
    rdchk("bw", pmis_pkg::ADDR_BW, 32'h0C08);
    rdchk("hold", pmis_pkg::ADDR_HOLD, 32'h0210);
    rdchk("status", pmis_pkg::ADDR_STATUS, 32'h19);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 1, err);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge mclk) inputSelPin <= i[0];
      waitN(3);
      chk("pinSel", i, selInputOne);
    end
    apb(1'b1, pmis_pkg::ADDR_CTRL, 32'h1E);
    @(posedge mclk) inputSelPin <= 1'b0;
    waitN(3);
    chk("regSel", 1, selInputOne);
    apb(1'b1, pmis_pkg::ADDR_BW, 32'h011F);
    apb(1'b1, pmis_pkg::ADDR_CTRL, 32'h06);
    waitN(3);
    chk("pinSel0", 0, selInputOne);
    @(posedge mclk) clkZeroOn <= 1'b1;
    waitMode(pmis_pkg::ST_ACQ);
    waitN(2);
    chk("fast", 1, fastBwActive);
    chk("fastBw", 32'h0A, activeBw);
    waitMode(pmis_pkg::ST_LOCK);
    waitN(2);
    chk("normBw", 32'h10, activeBw);
    chk("lol", 0, lockLostIndicator);
    rdchk("statLock", pmis_pkg::ADDR_STATUS, 32'h13);
    waitN(200);
    @(posedge mclk) clkZeroOn <= 1'b0;
    waitMode(pmis_pkg::ST_HOLD);
    err = 1'b1;
    for (int i = 0; i < 60 && (err !== 1'b0 || rd[7] !== 1'b0); i++)
      apb(1'b0, pmis_pkg::ADDR_STATUS, 32'h0);
    chk("holdFreq", FW, holdoverFreq);
    rdchk("holdReg", pmis_pkg::ADDR_HOLDFRQ, FW);
    @(posedge mclk) clkZeroOn <= 1'b1;
    waitMode(pmis_pkg::ST_ACQ);
    waitMode(pmis_pkg::ST_LOCK);
    @(posedge mclk) inputSelPin <= 1'b1;
    waitMode(pmis_pkg::ST_HOLD);
    apb(1'b1, pmis_pkg::ADDR_REF, 32'h1000_0401);
    waitN(2);
    chk("noApply", 0, extRefSelect);
    apb(1'b1, pmis_pkg::ADDR_CTRL, 32'h06);
    waitN(2);
    chk("ext", 1, extRefSelect);
    chk("cap", 0, loadCapEnable);
    chk("prediv4", 4, refPreDiv);
    chk("adjHi", 32'h00C8, xtalAdjust);
    apb(1'b1, pmis_pkg::ADDR_REF, 32'hF000_0400);
    apb(1'b1, pmis_pkg::ADDR_CTRL, 32'h06);
    waitN(2);
    chk("adjLo", 32'hFF38, xtalAdjust);
    chk("capOn", 1, loadCapEnable);
    apb(1'b1, pmis_pkg::ADDR_DCO, 32'h0001_2345);
    waitN(2);
    chk("num", 32'h0001_2345, innerFbNumerator);
    apb(1'b1, pmis_pkg::ADDR_CTRL, 32'h26);
    @(posedge mclk) inputSelPin <= 1'b0;
    waitN(20);
    chk("outer", 0, outerLoopEnable);
    chk("dcoMode", pmis_pkg::ST_FREE, modeCode);
    @(posedge mclk) clkZeroOn <= 1'b0;
    apb(1'b1, pmis_pkg::ADDR_CTRL, 32'h01);
    waitN(2);
    chk("hardInit", pmis_pkg::ST_INIT, modeCode);
    waitMode(pmis_pkg::ST_FREE);
    chk("extRld", 0, extRefSelect);
    chk("predivRld", 1, refPreDiv);
    chk("outerRld", 1, outerLoopEnable);
    lockDelay <= 8'hC8;
    @(posedge mclk) clkZeroOn <= 1'b1;
    waitMode(pmis_pkg::ST_ACQ);
    @(posedge mclk) clkZeroOn <= 1'b0;
    waitMode(pmis_pkg::ST_FREE);
    results();
  end
endmodule
`default_nettype wire
